//--- common/amx_params.svh
// constants for the audio mixer register bank
`ifndef AMX_PARAMS_SVH
`define AMX_PARAMS_SVH

// configuration ports, absolute i/o addresses
`define AMX_CFG_UNLOCK_PORT 16'h00fb
`define AMX_CFG_CLEAR_PORT  16'h00e0
`define AMX_CFG_ADDR_PORT   16'h00e1
`define AMX_CFG_LOCK_PORT   16'h00f9
`define AMX_CFG_CLEAR_VAL   8'h00
`define AMX_CFG_RESET       8'h04
`define AMX_CFG_SEL_LSB     0
`define AMX_CFG_EN_BIT      2
`define AMX_CFG_WMASK       8'h07

// joystick port and relocatable block
`define AMX_JOY_PORT        16'h0201
`define AMX_BLOCK_BASE      12'h022
`define AMX_NIBBLE_PRIMARY  4'h2
`define AMX_OFF_SYNTH_LAST  4'h3
`define AMX_OFF_MIX_INDEX   4'h4
`define AMX_OFF_MIX_DATA    4'h5
`define AMX_OFF_RESET_STAT  4'h6
`define AMX_OFF_POWER       4'h7

// mixer index port fields
`define AMX_IDX_PEND_BIT    0
`define AMX_IDX_LSB         1
`define AMX_IDX_MSB         5

// mixer indices
`define AMX_IX_RESET        6'h00
`define AMX_IX_VOICE_C      6'h04
`define AMX_IX_MIC_C        6'h0a
`define AMX_IX_REC_C        6'h0c
`define AMX_IX_STEREO_C     6'h0e
`define AMX_IX_VOICE_E      6'h14
`define AMX_IX_MIC_E        6'h1a
`define AMX_IX_REC_E        6'h1c
`define AMX_IX_STEREO_E     6'h1e
`define AMX_IX_MAIN_C       6'h22
`define AMX_IX_SYNTH_C      6'h26
`define AMX_IX_DISC_C       6'h28
`define AMX_IX_LINE_C       6'h2e
`define AMX_IX_MAIN_E       6'h32
`define AMX_IX_SYNTH_E      6'h36
`define AMX_IX_DISC_E       6'h38
`define AMX_IX_LINE_E       6'h3e

// mixer write masks and reset values
`define AMX_WM_LVL_C        8'hee
`define AMX_WM_MIC_C        8'h06
`define AMX_WM_REC_C        8'h06
`define AMX_WM_REC_E        8'h07
`define AMX_WM_STEREO       8'h02
`define AMX_WM_LVL_E        8'hff
`define AMX_RST_LOUD        8'h88
`define AMX_RST_QUIET       8'h00
`define AMX_STEREO_BIT      1
`define AMX_PWR_WMASK       8'h3f

// timing
`define AMX_CLK_NS          20
`define AMX_MIX_PROC_NS     100
`define AMX_MIX_PROC_CYC    ((`AMX_MIX_PROC_NS + `AMX_CLK_NS - 1) / `AMX_CLK_NS)

`endif

//--- common/amx_pkg.sv
// types for the audio mixer register bank
package amx_pkg;
	typedef enum logic [1:0] {
		AMX_LOCKED   = 2'b00,
		AMX_UNLOCKED = 2'b01,
		AMX_ARMED    = 2'b10
	} amx_cfg_state_type;
endpackage

//--- rtl/amx_register_bank.sv
// i/o mapped register front end: base config, block decode, indexed mixer
`include "amx_params.svh"

module amx_register_bank
	import amx_pkg::*;
#(
	parameter int PROC_CYC = `AMX_MIX_PROC_CYC
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_b_in,
	input  wire logic [15:0] io_addr_in,
	input  wire logic [7:0]  io_data_in,
	input  wire logic        io_rd_in,
	input  wire logic        io_wr_in,
	input  wire logic        ext_mode_in,
	input  wire logic [2:0]  activity_n_in,
	input  wire logic        power_up_in,
	input  wire logic        midi_idle_in,
	output logic      [7:0]  io_data_out,
	output logic             io_data_oe_out,
	output logic             synth_cs_out,
	output logic             joy_rd_strobe_out,
	output logic             joy_wr_strobe_out,
	output logic             audio_enable_out,
	output logic      [1:0]  base_select_out,
	output logic             sw_reset_out,
	output logic             fifo_reset_out,
	output logic      [5:0]  power_ctrl_out,
	output logic      [2:0]  record_source_out,
	output logic             stereo_playback_out,
	output logic      [3:0]  main_left_out,
	output logic      [3:0]  main_right_out
);

	localparam logic [4:0] SLOT_REC_C    = 5'(`AMX_IX_REC_C >> 1);
	localparam logic [4:0] SLOT_REC_E    = 5'(`AMX_IX_REC_E >> 1);
	localparam logic [4:0] SLOT_STEREO_C = 5'(`AMX_IX_STEREO_C >> 1);
	localparam logic [4:0] SLOT_MAIN_C   = 5'(`AMX_IX_MAIN_C >> 1);
	localparam logic [4:0] SLOT_MAIN_E   = 5'(`AMX_IX_MAIN_E >> 1);
	localparam logic [4:0] SLOT_VOICE_C  = 5'(`AMX_IX_VOICE_C >> 1);
	localparam logic [3:0] PROC_LOAD     = 4'(PROC_CYC);

	// writable bits per mixer index; reserved and legacy filter bits drop out
	function automatic logic [7:0] mix_wmask(input logic [5:0] ix);
		case (ix)
			`AMX_IX_VOICE_C, `AMX_IX_MAIN_C, `AMX_IX_SYNTH_C,
			`AMX_IX_DISC_C, `AMX_IX_LINE_C:   mix_wmask = `AMX_WM_LVL_C;
			`AMX_IX_MIC_C:                    mix_wmask = `AMX_WM_MIC_C;
			`AMX_IX_REC_C:                    mix_wmask = `AMX_WM_REC_C;
			`AMX_IX_REC_E:                    mix_wmask = `AMX_WM_REC_E;
			`AMX_IX_STEREO_C, `AMX_IX_STEREO_E: mix_wmask = `AMX_WM_STEREO;
			`AMX_IX_VOICE_E, `AMX_IX_MIC_E, `AMX_IX_MAIN_E, `AMX_IX_SYNTH_E,
			`AMX_IX_DISC_E, `AMX_IX_LINE_E:   mix_wmask = `AMX_WM_LVL_E;
			default:                          mix_wmask = 8'h00;
		endcase
	endfunction

	function automatic logic [7:0] mix_rstval(input logic [5:0] ix);
		case (ix)
			`AMX_IX_VOICE_C, `AMX_IX_VOICE_E, `AMX_IX_MAIN_C,
			`AMX_IX_MAIN_E, `AMX_IX_SYNTH_C, `AMX_IX_SYNTH_E: mix_rstval = `AMX_RST_LOUD;
			default:                                          mix_rstval = `AMX_RST_QUIET;
		endcase
	endfunction

	// compatible two-bit source onto the extended source code
	function automatic logic [2:0] rec_compat_map(input logic [1:0] code);
		case (code)
			2'b01:   rec_compat_map = 3'h2;
			2'b11:   rec_compat_map = 3'h6;
			default: rec_compat_map = 3'h0;
		endcase
	endfunction

	// pin synchronisers
	logic [15:0] addr_s1_r;
	logic [15:0] addr_s2_r;
	logic [7:0]  data_s1_r;
	logic [7:0]  data_s2_r;
	logic        rd_s1_r;
	logic        rd_s2_r;
	logic        rd_s3_r;
	logic        wr_s1_r;
	logic        wr_s2_r;
	logic        wr_s3_r;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			addr_s1_r <= 16'h0000;
			addr_s2_r <= 16'h0000;
			data_s1_r <= 8'h00;
			data_s2_r <= 8'h00;
			rd_s1_r   <= 1'b0;
			rd_s2_r   <= 1'b0;
			rd_s3_r   <= 1'b0;
			wr_s1_r   <= 1'b0;
			wr_s2_r   <= 1'b0;
			wr_s3_r   <= 1'b0;
		end else begin
			addr_s1_r <= io_addr_in;
			addr_s2_r <= addr_s1_r;
			data_s1_r <= io_data_in;
			data_s2_r <= data_s1_r;
			rd_s1_r   <= io_rd_in;
			rd_s2_r   <= rd_s1_r;
			rd_s3_r   <= rd_s2_r;
			wr_s1_r   <= io_wr_in;
			wr_s2_r   <= wr_s1_r;
			wr_s3_r   <= wr_s2_r;
		end
	end

	amx_cfg_state_type cfg_state_r;
	amx_cfg_state_type cfg_state_nxt;
	logic [7:0]  cfg_r;
	logic [4:0]  idx_r;
	logic [3:0]  pend_cnt_r;
	logic [1:0]  rst_ctl_r;
	logic [5:0]  pwr_r;
	logic [7:0]  rdata_r;
	logic [7:0]  mix_mem [0:31];

	wire         rd_ev     = rd_s2_r & ~rd_s3_r;
	wire         wr_ev     = wr_s2_r & ~wr_s3_r;
	wire         audio_en  = cfg_r[`AMX_CFG_EN_BIT];
	wire  [1:0]  base_sel  = cfg_r[`AMX_CFG_SEL_LSB +: 2];
	wire  [11:0] blk_page  = `AMX_BLOCK_BASE + {10'h000, base_sel};
	wire  [3:0]  blk_nib   = blk_page[3:0];
	wire         blk_hit   = audio_en & (addr_s2_r[15:4] == blk_page);
	wire  [3:0]  off       = addr_s2_r[3:0];
	wire         cfg_hit   = (addr_s2_r == `AMX_CFG_ADDR_PORT);
	wire         joy_hit   = audio_en & (addr_s2_r == `AMX_JOY_PORT);
	wire         synth_hit = blk_hit & (off <= `AMX_OFF_SYNTH_LAST);
	wire         idx_hit   = blk_hit & (off == `AMX_OFF_MIX_INDEX);
	wire         dat_hit   = blk_hit & (off == `AMX_OFF_MIX_DATA);
	wire         rsc_hit   = blk_hit & (off == `AMX_OFF_RESET_STAT);
	wire         pwr_hit   = blk_hit & (off == `AMX_OFF_POWER);
	wire         own_read  = cfg_hit | idx_hit | dat_hit | rsc_hit | pwr_hit;
	wire         mix_wr    = wr_ev & dat_hit;
	wire  [5:0]  mix_ix    = {idx_r, 1'b0};
	wire         mix_clear = mix_wr & (mix_ix == `AMX_IX_RESET);
	wire         mix_pend  = (pend_cnt_r != 4'h0);
	wire         cfg_wr_ok = wr_ev & cfg_hit & (cfg_state_r == AMX_ARMED);
	wire  [7:0]  idx_read  = {2'b00, idx_r, mix_pend};
	wire  [7:0]  stat_read = {activity_n_in, 1'b0, power_up_in, midi_idle_in, rst_ctl_r};
	wire  [7:0]  rdata_nxt = cfg_hit ? cfg_r :
	                         idx_hit ? idx_read :
	                         dat_hit ? mix_mem[idx_r] :
	                         rsc_hit ? stat_read :
	                         pwr_hit ? {2'b00, pwr_r} : 8'h00;

	// configuration lock sequence
	always_comb begin
		cfg_state_nxt = cfg_state_r;
		if (wr_ev && addr_s2_r == `AMX_CFG_LOCK_PORT) begin
			cfg_state_nxt = AMX_LOCKED;
		end else if (wr_ev) begin
			case (cfg_state_r)
				AMX_LOCKED: begin
					if (addr_s2_r == `AMX_CFG_UNLOCK_PORT)
						cfg_state_nxt = AMX_UNLOCKED;
				end
				AMX_UNLOCKED: begin
					if (addr_s2_r == `AMX_CFG_CLEAR_PORT && data_s2_r == `AMX_CFG_CLEAR_VAL)
						cfg_state_nxt = AMX_ARMED;
				end
				AMX_ARMED: cfg_state_nxt = AMX_ARMED;
				default:   cfg_state_nxt = AMX_LOCKED;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cfg_state_r <= AMX_LOCKED;
			cfg_r       <= `AMX_CFG_RESET;
		end else begin
			cfg_state_r <= cfg_state_nxt;
			if (cfg_wr_ok)
				cfg_r <= data_s2_r & `AMX_CFG_WMASK;
		end
	end

	// index, pending counter, reset control, power control, read data
	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			idx_r      <= 5'h00;
			pend_cnt_r <= 4'h0;
			rst_ctl_r  <= 2'b00;
			pwr_r      <= 6'h00;
			rdata_r    <= 8'h00;
		end else begin
			if (wr_ev && idx_hit)
				idx_r <= data_s2_r[`AMX_IDX_MSB:`AMX_IDX_LSB];
			if (mix_wr)
				pend_cnt_r <= PROC_LOAD;
			else if (mix_pend)
				pend_cnt_r <= pend_cnt_r - 4'h1;
			if (wr_ev && rsc_hit)
				rst_ctl_r <= data_s2_r[1:0];
			if (wr_ev && pwr_hit)
				pwr_r <= data_s2_r[5:0];
			rdata_r <= rdata_nxt;
		end
	end

	// mixer storage; cleared only by pin reset or index 00h, never by sw reset
	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : g_mix
			always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
				if (!rst_b_in)
					mix_mem[g] <= mix_rstval(6'(2 * g));
				else if (mix_clear)
					mix_mem[g] <= mix_rstval(6'(2 * g));
				else if (mix_wr && idx_r == 5'(g))
					mix_mem[g] <= data_s2_r & mix_wmask(6'(2 * g));
			end
		end
	endgenerate

	assign io_data_out        = rdata_r;
	assign io_data_oe_out     = rd_s2_r & rd_s3_r & own_read;
	assign synth_cs_out       = (rd_s2_r | wr_s2_r) & synth_hit;
	assign joy_rd_strobe_out  = rd_ev & joy_hit;
	assign joy_wr_strobe_out  = wr_ev & joy_hit;
	assign audio_enable_out   = audio_en;
	assign base_select_out    = base_sel;
	assign sw_reset_out       = rst_ctl_r[0];
	assign fifo_reset_out     = rst_ctl_r[1] & ext_mode_in;
	assign power_ctrl_out     = pwr_r;
	assign record_source_out  = ext_mode_in ? mix_mem[SLOT_REC_E][2:0]
	                                        : rec_compat_map(mix_mem[SLOT_REC_C][2:1]);
	assign stereo_playback_out = ~ext_mode_in & mix_mem[SLOT_STEREO_C][`AMX_STEREO_BIT];
	assign main_left_out      = ext_mode_in ? mix_mem[SLOT_MAIN_E][7:4] : {mix_mem[SLOT_MAIN_C][7:5], 1'b0};
	assign main_right_out     = ext_mode_in ? mix_mem[SLOT_MAIN_E][3:0] : {mix_mem[SLOT_MAIN_C][3:1], 1'b0};

	// cycles since the last mixer data write, saturating; reference for the pending checks
	logic [4:0] since_wr_r;

	always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			since_wr_r <= 5'h1f;
		else if (mix_wr)
			since_wr_r <= 5'h00;
		else if (since_wr_r != 5'h1f)
			since_wr_r <= since_wr_r + 5'h01;
	end

	cfg_locked_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(cfg_state_r == AMX_LOCKED && wr_ev && cfg_hit) |=> $stable(cfg_r))
		else $error("address config changed while locked");

	cfg_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(cfg_state_r == AMX_UNLOCKED && wr_ev && addr_s2_r == `AMX_CFG_CLEAR_PORT && data_s2_r != 8'h00)
		|=> cfg_state_r == AMX_UNLOCKED)
		else $error("nonzero clear write armed config");

	cfg_relock_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(wr_ev && addr_s2_r == `AMX_CFG_LOCK_PORT) |=> cfg_state_r == AMX_LOCKED)
		else $error("lock write did not relock");

	base_decode_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(audio_en && base_sel == 2'b11 && addr_s2_r == 16'h0254) |-> idx_hit)
		else $error("block not decoded at selected base");

	primary_nib_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(base_sel == 2'b00) |-> blk_nib == `AMX_NIBBLE_PRIMARY)
		else $error("primary block nibble wrong");

	audio_off_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		!audio_en |-> !synth_cs_out && !joy_wr_strobe_out && !joy_rd_strobe_out)
		else $error("disabled audio still decoding");

	cfg_rsvd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		cfg_r[7:3] == 5'h00)
		else $error("config reserved bits nonzero");

	synth_cs_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(wr_s2_r && blk_hit) |-> synth_cs_out == (off <= 4'h3))
		else $error("synth select decode wrong");

	joy_strobe_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(wr_ev && joy_hit) |-> joy_wr_strobe_out ##1 !joy_wr_strobe_out)
		else $error("joystick write strobe not one cycle");

	pend_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(since_wr_r < {1'b0, PROC_LOAD}) |-> mix_pend)
		else $error("pending flag dropped early");

	pend_clear_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(since_wr_r >= {1'b0, PROC_LOAD}) |-> !mix_pend)
		else $error("pending flag stuck");

	mix_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		mix_clear |=> mix_mem[SLOT_VOICE_C] == 8'h88 && mix_mem[SLOT_REC_C] == 8'h00)
		else $error("mixer reset did not restore values");

	sw_reset_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(sw_reset_out && !mix_wr) |=> $stable(mix_mem[SLOT_MAIN_E]))
		else $error("software reset touched mixer");

	idx_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(io_data_oe_out && idx_hit && $stable(addr_s2_r))
		|-> io_data_out == {2'b00, $past(idx_r), $past(mix_pend)})
		else $error("index read value wrong");

	filter_bits_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		mix_mem[SLOT_REC_C][5:3] == 3'h0 && mix_mem[SLOT_STEREO_C][5] == 1'b0)
		else $error("legacy filter bits stored");

	stereo_mode_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		stereo_playback_out |-> !ext_mode_in)
		else $error("stereo selected outside compatible mode");

	joy_rd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(rd_ev && joy_hit) |-> joy_rd_strobe_out ##1 !joy_rd_strobe_out)
		else $error("joystick read strobe not one cycle");

	cfg_arm_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(cfg_state_r == AMX_UNLOCKED && wr_ev && addr_s2_r == `AMX_CFG_CLEAR_PORT && data_s2_r == 8'h00)
		|=> cfg_state_r == AMX_ARMED)
		else $error("zero clear write did not arm config");

	idx_write_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(wr_ev && idx_hit) |=> {2'b00, idx_r, 1'b0} == ($past(data_s2_r) & 8'h3e))
		else $error("index port write stored wrong bits");

	voice_rsvd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(mix_mem[SLOT_VOICE_C] & 8'h11) == 8'h00)
		else $error("compatible voice reserved bits stored");

	mic_rsvd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(mix_mem[5'(`AMX_IX_MIC_C >> 1)] & 8'hf9) == 8'h00)
		else $error("compatible mic reserved bits stored");

	rec_rsvd_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		mix_mem[SLOT_REC_E][7:3] == 5'h00)
		else $error("extended source upper bits stored");

	rec_line_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(!ext_mode_in && mix_mem[SLOT_REC_C][2:1] == 2'b11) |-> record_source_out == 3'h6)
		else $error("compatible line source not mapped");

	main_ext_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		ext_mode_in |-> {main_left_out, main_right_out} == mix_mem[SLOT_MAIN_E])
		else $error("extended main level not four bits");

	synth_no_oe_a: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
		(rd_s2_r && synth_hit) |-> !io_data_oe_out)
		else $error("data driven at synth offsets");

endmodule

//--- verification/audio_mixer_register_bank_tb_top.sv
// self-checking bench for the audio mixer register bank
`include "amx_params.svh"
module audio_mixer_register_bank_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PROC = 15;
	logic        sys_clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [15:0] io_addr_in = 16'h0000;
	logic [7:0]  io_data_in = 8'h00;
	logic        io_rd_in = 1'b0;
	logic        io_wr_in = 1'b0;
	logic        ext_mode_in = 1'b0;
	logic [2:0]  activity_n_in = 3'h7;
	logic        power_up_in = 1'b1;
	logic        midi_idle_in = 1'b1;
	logic [7:0]  io_data_out;
	logic        io_data_oe_out, synth_cs_out, joy_rd_strobe_out, joy_wr_strobe_out, audio_enable_out;
	logic [1:0]  base_select_out;
	logic        sw_reset_out, fifo_reset_out, stereo_playback_out;
	logic [5:0]  power_ctrl_out;
	logic [2:0]  record_source_out;
	logic [3:0]  main_left_out, main_right_out;
	int          n_mismatch = 0;
	int          checks = 0;
	int          n_joy_rd = 0;
	int          n_joy_wr = 0;
	int          n_cs = 0;
	logic [7:0]  rd_val;
	logic        rd_oe;
	logic [15:0] blk = 16'h0220;
	logic [5:0]  ixs [16] = '{6'h04, 6'h0a, 6'h0c, 6'h0e, 6'h14, 6'h1a, 6'h1c, 6'h1e,
		6'h22, 6'h26, 6'h28, 6'h2e, 6'h32, 6'h36, 6'h38, 6'h3e};

	amx_register_bank #(.PROC_CYC(PROC)) i_dut (.sys_clk_in, .rst_b_in, .io_addr_in, .io_data_in,
		.io_rd_in, .io_wr_in, .ext_mode_in, .activity_n_in, .power_up_in, .midi_idle_in, .io_data_out,
		.io_data_oe_out, .synth_cs_out, .joy_rd_strobe_out, .joy_wr_strobe_out, .audio_enable_out,
		.base_select_out, .sw_reset_out, .fifo_reset_out, .power_ctrl_out, .record_source_out,
		.stereo_playback_out, .main_left_out, .main_right_out);

	initial begin
		forever #10 sys_clk_in = ~sys_clk_in;
	end

	always @(posedge sys_clk_in) begin
		if (joy_rd_strobe_out === 1'b1)
			n_joy_rd <= n_joy_rd + 1;
		if (joy_wr_strobe_out === 1'b1)
			n_joy_wr <= n_joy_wr + 1;
		if (synth_cs_out === 1'b1)
			n_cs <= n_cs + 1;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic io_write(input logic [15:0] a, input logic [7:0] d);
		io_addr_in = a;
		io_data_in = d;
		repeat (2) @(negedge sys_clk_in);
		io_wr_in = 1'b1;
		repeat (3) @(negedge sys_clk_in);
		io_wr_in = 1'b0;
		repeat (3) @(negedge sys_clk_in);
	endtask

	// data and enable valid three edges after the strobe rises
	task automatic io_read(input logic [15:0] a);
		io_addr_in = a;
		repeat (2) @(negedge sys_clk_in);
		io_rd_in = 1'b1;
		repeat (3) @(negedge sys_clk_in);
		rd_oe = io_data_oe_out;
		rd_val = io_data_out;
		@(negedge sys_clk_in);
		io_rd_in = 1'b0;
		repeat (3) @(negedge sys_clk_in);
	endtask

	task automatic cfg(input logic [7:0] e0, input logic [7:0] e1);
		io_write(`AMX_CFG_UNLOCK_PORT, 8'h5a);
		io_write(`AMX_CFG_CLEAR_PORT, e0);
		io_write(`AMX_CFG_ADDR_PORT, e1);
		io_write(`AMX_CFG_LOCK_PORT, 8'ha5);
	endtask

	task automatic mix_wr(input logic [5:0] ix, input logic [7:0] d);
		io_write(blk + 16'h4, {2'b00, ix});
		io_write(blk + 16'h5, d);
	endtask

	task automatic mix_rd(input logic [5:0] ix);
		io_write(blk + 16'h4, {2'b00, ix});
		io_read(blk + 16'h5);
	endtask

	function automatic logic [7:0] mask_of(input logic [5:0] ix);
		case (ix)
			6'h0a, 6'h0c: return 8'h06;
			6'h1c: return 8'h07;
			6'h0e, 6'h1e: return 8'h02;
			default: return ix[4] ? 8'hff : 8'hee;
		endcase
	endfunction

	function automatic logic [7:0] rst_of(input logic [5:0] ix);
		return (ix inside {6'h04, 6'h14, 6'h22, 6'h32, 6'h26, 6'h36}) ? 8'h88 : 8'h00;
	endfunction

	function automatic logic [2:0] src_of(input logic [1:0] c);
		case (c)
			2'b01: return 3'h2;
			2'b11: return 3'h6;
			default: return 3'h0;
		endcase
	endfunction

	initial begin
		#200000;
		n_mismatch++;
		$display("unexpected at %0t: run timed out", $time);
		tally_and_finish();
	end

	initial begin
		logic [7:0] d;
		void'($urandom(37));
		repeat (10) @(negedge sys_clk_in);
		rst_b_in = 1'b1;
		@(negedge sys_clk_in);
		io_read(`AMX_CFG_ADDR_PORT);
		check(rd_val, 8'h04);
		check({7'h00, rd_oe}, 8'h01);
		check({7'h00, audio_enable_out}, 8'h01);
		io_write(`AMX_CFG_ADDR_PORT, 8'h05);
		check({6'h00, base_select_out}, 8'h00);
		cfg(8'h3c, 8'h05);
		check({6'h00, base_select_out}, 8'h00);
		for (int c = 3; c >= 0; c--) begin
			cfg(8'h00, 8'hfc | 8'(c));
			io_read(`AMX_CFG_ADDR_PORT);
			check(rd_val, 8'h04 | 8'(c));
			check({6'h00, base_select_out}, 8'(c));
			blk = 16'h0220 + 16'(c * 16);
			io_write(blk + 16'h4, 8'h1c | 8'(c << 6));
			io_read(blk + 16'h4);
			check(rd_val, 8'h1c);
			if (c != 3) begin
				io_read(16'h0254);
				check({7'h00, rd_oe}, 8'h00);
			end
		end
		cfg(8'h00, 8'h00);
		check({7'h00, audio_enable_out}, 8'h00);
		io_read(blk + 16'h4);
		check({7'h00, rd_oe}, 8'h00);
		cfg(8'h00, 8'h04);
		foreach (ixs[i]) begin
			mix_rd(ixs[i]);
			check(rd_val, rst_of(ixs[i]));
		end
		foreach (ixs[i]) begin
			d = 8'($urandom);
			mix_wr(ixs[i], d);
			io_read(blk + 16'h4);
			check(rd_val, {2'b00, ixs[i]} | 8'h01);
			mix_rd(ixs[i]);
			check(rd_val, d & mask_of(ixs[i]));
		end
		repeat (PROC + 5) @(negedge sys_clk_in);
		io_read(blk + 16'h4);
		check(rd_val, 8'h3e);
		for (int k = 0; k < 8; k++) begin
			mix_wr(6'h0c, 8'h38 | 8'(k << 1));
			mix_wr(6'h1c, 8'h38 | 8'(k));
			ext_mode_in = 1'b0;
			@(negedge sys_clk_in);
			check({5'h00, record_source_out}, {5'h00, src_of(2'(k))});
			ext_mode_in = 1'b1;
			@(negedge sys_clk_in);
			check({5'h00, record_source_out}, 8'(k));
		end
		mix_wr(6'h0e, 8'h22);
		mix_wr(6'h22, 8'hb6);
		mix_wr(6'h32, 8'h5c);
		check({7'h00, stereo_playback_out}, 8'h00);
		check({main_left_out, main_right_out}, 8'h5c);
		ext_mode_in = 1'b0;
		@(negedge sys_clk_in);
		check({7'h00, stereo_playback_out}, 8'h01);
		check({main_left_out, main_right_out}, 8'ha6);
		io_write(blk + 16'h6, 8'h01);
		check({7'h00, sw_reset_out}, 8'h01);
		mix_rd(6'h22);
		check(rd_val, 8'ha6);
		activity_n_in = 3'($urandom);
		power_up_in = 1'($urandom);
		midi_idle_in = 1'($urandom);
		io_write(blk + 16'h6, 8'h02);
		io_read(blk + 16'h6);
		check(rd_val, {activity_n_in, 1'b0, power_up_in, midi_idle_in, 2'b10});
		check({7'h00, fifo_reset_out}, 8'h00);
		ext_mode_in = 1'b1;
		@(negedge sys_clk_in);
		check({7'h00, fifo_reset_out}, 8'h01);
		mix_wr(6'h00, 8'h5a);
		foreach (ixs[i]) begin
			mix_rd(ixs[i]);
			check(rd_val, rst_of(ixs[i]));
		end
		d = 8'($urandom);
		io_write(blk + 16'h7, d);
		check({2'b00, power_ctrl_out}, d & `AMX_PWR_WMASK);
		io_read(blk + 16'h7);
		check(rd_val, d & `AMX_PWR_WMASK);
		io_write(`AMX_JOY_PORT, 8'h0f);
		io_read(`AMX_JOY_PORT);
		check(8'(n_joy_wr), 8'h01);
		check(8'(n_joy_rd), 8'h01);
		io_read(blk + 16'h8);
		check(8'(n_cs), 8'h00);
		io_read(blk + 16'h2);
		check({7'h00, rd_oe}, 8'h00);
		check(8'(n_cs > 0), 8'h01);
		tally_and_finish();
	end
endmodule
